/* dv/converter_front_model.sv */
// Far-side model of the analogue front end that feeds the converter pins.
`timescale 1ns/1ps

// ==========================================================
// Front end: sample-and-hold of the levels that the bench sets.
module converter_front_model (
  input wire logic clk_i,
  input wire vbc_pkg::pins_t level_i,
  output vbc_pkg::pins_t pins_o
);
  // Levels change only on a clock edge. A real front end is asynchronous, but
  // stepping on the clock keeps the synchroniser latency known to the bench.
  always_ff @(posedge clk_i) begin
    pins_o <= level_i;
  end
endmodule // converter_front_model

/* dv/voiceband_baseband_converter_ctl_test.sv */
// Self-checking testbench for the voiceband and baseband converter control.
`timescale 1ns/1ps

module voiceband_baseband_converter_ctl_test;
  // ==========================================================
  // Signals.
  localparam int VDIV = 50; // Short voice period to keep the run brief.
  logic clk_i, rst_n_i, read_i, write_i, waitrequest_o;
  logic [7:0] address_i;
  logic [31:0] writedata_i, readdata_o, q;
  vbc_pkg::pins_t level, pins;
  logic in_sel_o, aux_in_hi_o, aux_out_hi_o;
  logic [3:0] play_gain_o;
  logic [vbc_pkg::VOICE_W-1:0] voice_dac_o;
  vbc_pkg::iq_t tx_iq_o, prev;
  logic [vbc_pkg::DAC_W-1:0] ramp_dac_o, last;
  logic [vbc_pkg::AFC_W-1:0] afc_dac_o;
  logic [9:0] coef [16];
  logic [7:0] cv [5] = '{8'h01, 8'h02, 8'h04, 8'hf0, 8'ha6};
  int n_mismatch, n_checks, i, ch, cyc, lastc;

  // ==========================================================
  // Design, front end and clock.
  vbc_ctl #(.VOICE_DIV(VDIV), .BIT_DIV(37), .FIFO_DEPTH(4)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .pins_i(pins), .in_sel_o(in_sel_o),
    .aux_in_hi_o(aux_in_hi_o), .aux_out_hi_o(aux_out_hi_o), .play_gain_o(play_gain_o),
    .voice_dac_o(voice_dac_o), .tx_iq_o(tx_iq_o), .ramp_dac_o(ramp_dac_o),
    .afc_dac_o(afc_dac_o));
  converter_front_model front (.clk_i(clk_i), .level_i(level), .pins_o(pins));

  // The clock toggles every half period of 50 ns.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================================
  // Shared tasks.
  // Compares and counts; a mismatch is reported at once.
  task automatic check(input logic [31:0] got, input logic [31:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      n_mismatch++;
      $display("FAIL t=%0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  // One Avalon transfer: held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i <= a;
    writedata_i <= d;
    write_i <= wr;
    read_i <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 5000);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (n >= 5000) begin
      n_mismatch++;
      $display("FAIL t=%0t no bus answer", $time);
    end
  endtask

  // Reads a register and compares it with the expected word.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    bus(1'b0, a, 32'h0);
    check(q, want, "register read");
  endtask

  // Polls the status word until the given flag is set, with a bounded count.
  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      bus(1'b0, vbc_pkg::OFS_STATUS, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 200);
    check(q[b], 1, "status flag");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under 8000 cycles.
  initial begin
    repeat (40000) @(posedge clk_i);
    n_mismatch++;
    $display("FAIL t=%0t watchdog expired", $time);
    print_verdict();
  end

  // ==========================================================
  // Test sequence.
  initial begin
    rst_n_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    address_i = 8'h00;
    writedata_i = 32'h0;
    level = '0;
    level.mic = 13'h0a5c;
    level.aux = 13'h1b3e;
    level.rx.i = 10'h155;
    level.rx.q = 10'h2aa;
    level.bat_v = 10'h2a5;
    level.bat_id = 10'h15a;
    level.bat_t = 10'h3ff;
    repeat (12) @(posedge clk_i);
    check(waitrequest_o, 1, "waitrequest in reset");
    check({in_sel_o, aux_in_hi_o, aux_out_hi_o, play_gain_o, afc_dac_o}, 0, "reset outs");
    rst_n_i <= 1'b1;
    rd_chk(vbc_pkg::OFS_CTRL, 32'h0);
    rd_chk(vbc_pkg::OFS_STATUS, 32'h8);
    rd_chk(vbc_pkg::OFS_TX_BITS, 32'h0);
    $display("test reset done");
    // Control bits reach the selector and gain pins; upper write bits are dropped.
    for (i = 0; i < 5; i++) begin
      bus(1'b1, vbc_pkg::OFS_CTRL, {24'hffffff, cv[i]});
      rd_chk(vbc_pkg::OFS_CTRL, {24'h0, cv[i]});
      check({play_gain_o, 1'b0, aux_out_hi_o, aux_in_hi_o, in_sel_o}, cv[i] & 8'hf7, "pins");
    end
    $display("test control done");
    // Each input source in turn reaches the voice sample word.
    for (i = 0; i < 2; i++) begin
      bus(1'b1, vbc_pkg::OFS_CTRL, i);
      bus(1'b0, vbc_pkg::OFS_VOICE_IN, 32'h0);
      wait_flag(0);
      rd_chk(vbc_pkg::OFS_VOICE_IN, (i == 1) ? level.aux : level.mic);
    end
    bus(1'b1, vbc_pkg::OFS_VOICE_OUT, 32'hffff_1abc);
    rd_chk(vbc_pkg::OFS_VOICE_OUT, 32'h1abc);
    repeat (2 * VDIV + 4) @(posedge clk_i);
    check(voice_dac_o, 13'h1abc, "voice playback");
    $display("test voice done");
    // Receive samples, battery readings and the frequency word.
    bus(1'b0, vbc_pkg::OFS_RX_IQ, 32'h0);
    wait_flag(1);
    rd_chk(vbc_pkg::OFS_RX_IQ, 32'h02aa_0155);
    rd_chk(vbc_pkg::OFS_BAT_V, 32'h2a5);
    rd_chk(vbc_pkg::OFS_BAT_ID, 32'h15a);
    rd_chk(vbc_pkg::OFS_BAT_T, 32'h3ff);
    bus(1'b1, vbc_pkg::OFS_AFC, 32'hffff_1234);
    rd_chk(vbc_pkg::OFS_AFC, 32'h1234);
    check(afc_dac_o, 13'h1234, "frequency dac");
    // Unmapped places read zero and ignore writes.
    rd_chk(8'h2c, 32'h0);
    rd_chk(8'hfc, 32'h0);
    bus(1'b1, 8'h30, 32'hff);
    rd_chk(vbc_pkg::OFS_CTRL, 32'h1);
    $display("test readings done");
    // Ramp: load 16 coefficients, then play them on two bursts.
    for (i = 0; i < 16; i++) begin
      coef[i] = 10'(i * 37 + 5);
      bus(1'b1, vbc_pkg::OFS_RAMP, {12'h0, 4'(i), 6'h0, coef[i]});
    end
    level.burst <= 1'b1;
    repeat (16 * 37 + 40) @(posedge clk_i);
    check(ramp_dac_o, coef[15], "ramp hold");
    bus(1'b0, vbc_pkg::OFS_STATUS, 32'h0);
    check(q[2], 0, "ramp stopped");
    level.burst <= 1'b0;
    repeat (4) @(posedge clk_i);
    level.burst <= 1'b1;
    last = coef[15];
    i = 0;
    repeat (16 * 37 + 40) begin
      @(posedge clk_i);
      if (ramp_dac_o !== last) begin
        if (i < 16) check(ramp_dac_o, coef[i], "ramp step");
        i++;
        last = ramp_dac_o;
      end
    end
    check(i, 16, "ramp step count");
    $display("test ramp done");
    // Transmit: fill the FIFO while stalled, then drain it through the modulator.
    bus(1'b1, vbc_pkg::OFS_CTRL, 32'h0);
    for (i = 0; i < 4; i++) bus(1'b1, vbc_pkg::OFS_TX_BITS, 32'h0000_ffff);
    bus(1'b0, vbc_pkg::OFS_STATUS, 32'h0);
    check(q[4:3], 2'b10, "fifo full");
    bus(1'b1, vbc_pkg::OFS_CTRL, 32'h8);
    ch = 0;
    cyc = 0;
    lastc = 0;
    prev = tx_iq_o;
    repeat (2500) begin
      @(posedge clk_i);
      cyc++;
      if (tx_iq_o !== prev) begin
        if (ch > 0) check((cyc - lastc) % 37, 0, "bit spacing");
        ch++;
        lastc = cyc;
        prev = tx_iq_o;
      end
    end
    check(ch >= 32, 1, "modulator activity");
    bus(1'b0, vbc_pkg::OFS_STATUS, 32'h0);
    check(q[4:3], 2'b01, "fifo drained");
    $display("test transmit done");
    print_verdict();
  end
endmodule // voiceband_baseband_converter_ctl_test

/* verilog/vbc_ctl.sv */
// Voiceband and baseband converter control: transmit FIFO and top level.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

// ==========================================================
// Small synchronous FIFO with valid/ready on both sides.
module vbc_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];  // Storage words.
  logic [AW-1:0] wr_ptr;      // Next slot to fill.
  logic [AW-1:0] rd_ptr;      // Oldest slot.
  logic [AW:0] count;         // Words held; full and empty come from it.
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  // Pointers wrap at DEPTH, so a non power of two depth also works.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Data storage needs no reset.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule  // vbc_fifo

// ==========================================================
// Top level: Avalon-MM slave plus converter datapaths.
module vbc_ctl #(
  parameter int VOICE_DIV = vbc_pkg::VOICE_DIV,
  parameter int BIT_DIV = vbc_pkg::BIT_DIV,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire vbc_pkg::pins_t pins_i,
  output logic in_sel_o,
  output logic aux_in_hi_o,
  output logic aux_out_hi_o,
  output logic [3:0] play_gain_o,
  output logic [vbc_pkg::VOICE_W-1:0] voice_dac_o,
  output vbc_pkg::iq_t tx_iq_o,
  output logic [vbc_pkg::DAC_W-1:0] ramp_dac_o,
  output logic [vbc_pkg::AFC_W-1:0] afc_dac_o
);
  // ==========================================================
  // Declarations.
  vbc_pkg::pins_t sync1;  // First synchroniser stage, read only by sync2.
  vbc_pkg::pins_t sync2;  // Pins safe to use.
  vbc_pkg::ctrl_t ctrl;   // Control register.
  logic waitreq;          // Registered waitrequest.
  logic [31:0] rdata;     // Registered read data.
  logic [10:0] voice_cnt; // Divider for the 8 kHz voice tick.
  logic [5:0] bit_cnt;    // Divider for the 270 kHz bit tick.
  logic [vbc_pkg::VOICE_W-1:0] voice_in;   // Last captured voice sample.
  logic [vbc_pkg::VOICE_W-1:0] voice_pend; // Next playback sample.
  logic voice_new;        // Sticky: fresh voice sample waiting.
  vbc_pkg::iq_t rx_iq;    // Last captured receive sample pair.
  logic rx_new;           // Sticky: fresh receive pair waiting.
  logic [vbc_pkg::DAC_W-1:0] ramp_mem [vbc_pkg::RAMP_DEPTH];  // Envelope store.
  logic [3:0] ramp_idx;   // Current envelope position.
  logic ramp_run;         // Envelope playing.
  logic burst_q;          // Previous burst strobe level for edge detect.
  logic [vbc_pkg::TXW_W-1:0] tx_shift;  // Bits being modulated, LSB first.
  logic [4:0] tx_left;    // Bits remaining in tx_shift.
  logic [2:0] tx_hist;    // Last three bits, the table index.
  logic [1:0] tx_quad;    // Carrier phase quadrant.
  vbc_pkg::iq_t tx_iq;    // DAC pair register.
  logic [vbc_pkg::AFC_W-1:0] afc;  // Frequency DAC code.
  logic [vbc_pkg::TXW_W-1:0] fifo_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  // Top bit of the ramp index field in a ramp write word.
  localparam int RAMP_IDX_HI = vbc_pkg::RAMP_IDX_LSB + 3;

  // ==========================================================
  // Lookup-based GMSK mapping: the history picks a pulse-shaped point,
  // the quadrant rotates it. Table contents trade accuracy for area.
  function automatic vbc_pkg::iq_t gmsk_lut(input logic [1:0] quad, input logic [2:0] hist);
    logic [9:0] a;
    logic [9:0] b;
    vbc_pkg::iq_t r;
    a = 10'h000;
    b = 10'h000;
    r = '0;
    case (hist)
      3'h0: begin a = 10'h1ff; b = 10'h000; end
      3'h1: begin a = 10'h1d9; b = 10'h0c4; end
      3'h2: begin a = 10'h16a; b = 10'h16a; end
      3'h3: begin a = 10'h0c4; b = 10'h1d9; end
      3'h4: begin a = 10'h1d9; b = 10'h3c4; end
      3'h5: begin a = 10'h1ff; b = 10'h03c; end
      3'h6: begin a = 10'h16a; b = 10'h0c4; end
      default: begin a = 10'h0c4; b = 10'h16a; end
    endcase
    case (quad)
      2'h0: begin r.i = a; r.q = b; end
      2'h1: begin r.i = 10'h000 - b; r.q = a; end
      2'h2: begin r.i = 10'h000 - a; r.q = 10'h000 - b; end
      default: begin r.i = b; r.q = 10'h000 - a; end
    endcase
    return r;
  endfunction

  // ==========================================================
  // Decode and selection.
  wire hit_ctrl = (address_i == vbc_pkg::OFS_CTRL);
  wire hit_tx = (address_i == vbc_pkg::OFS_TX_BITS);
  wire hit_vin = (address_i == vbc_pkg::OFS_VOICE_IN);
  wire hit_vout = (address_i == vbc_pkg::OFS_VOICE_OUT);
  wire hit_rx = (address_i == vbc_pkg::OFS_RX_IQ);
  wire hit_ramp = (address_i == vbc_pkg::OFS_RAMP);
  wire hit_afc = (address_i == vbc_pkg::OFS_AFC);
  // A transmit write waits while the FIFO is full, so back-pressure reaches software.
  wire wr_block = write_i && hit_tx && !fifo_in_ready;
  wire take = (read_i || write_i) && waitreq && !wr_block;
  wire wr_done = write_i && !waitreq;
  wire rd_done = read_i && !waitreq;
  wire voice_tick = (voice_cnt == 11'(VOICE_DIV - 1));
  wire bit_tick = (bit_cnt == 6'(BIT_DIV - 1));
  wire burst_rise = sync2.burst && !burst_q;
  wire [vbc_pkg::VOICE_W-1:0] voice_sel = ctrl.in_sel ? sync2.aux : sync2.mic;
  // The modulator pulls a word only while enabled, so a disabled path lets the FIFO fill.
  wire tx_pull = (tx_left == 5'h00) && ctrl.tx_en;
  wire tx_load = tx_pull && fifo_out_valid;
  wire tx_step = bit_tick && ctrl.tx_en && (tx_left != 5'h00);
  wire [31:0] status = {27'h0, !fifo_in_ready, !fifo_out_valid, ramp_run, rx_new, voice_new};
  logic [31:0] rd_mux;
  always_comb begin
    if (hit_ctrl) begin
      rd_mux = {24'h0, ctrl};
    end else if (address_i == vbc_pkg::OFS_STATUS) begin
      rd_mux = status;
    end else if (hit_vin) begin
      rd_mux = {19'h0, voice_in};
    end else if (hit_vout) begin
      rd_mux = {19'h0, voice_pend};
    end else if (hit_rx) begin
      rd_mux = {6'h0, rx_iq.q, 6'h0, rx_iq.i};
    end else if (hit_ramp) begin
      rd_mux = {12'h0, ramp_idx, 6'h0, ramp_dac_o};
    end else if (hit_afc) begin
      rd_mux = {19'h0, afc};
    end else if (address_i == vbc_pkg::OFS_BAT_V) begin
      rd_mux = {22'h0, sync2.bat_v};
    end else if (address_i == vbc_pkg::OFS_BAT_ID) begin
      rd_mux = {22'h0, sync2.bat_id};
    end else if (address_i == vbc_pkg::OFS_BAT_T) begin
      rd_mux = {22'h0, sync2.bat_t};
    end else begin
      rd_mux = 32'h0000_0000;  // Unmapped reads return zero.
    end
  end

  // ==========================================================
  // Outputs straight from registers; gain selects are the control bits.
  assign readdata_o = rdata;
  assign waitrequest_o = waitreq;
  assign in_sel_o = ctrl.in_sel;
  assign aux_in_hi_o = ctrl.aux_in_hi;
  assign aux_out_hi_o = ctrl.aux_out_hi;
  assign play_gain_o = ctrl.play_gain;
  assign tx_iq_o = tx_iq;
  assign afc_dac_o = afc;

  // ==========================================================
  // Transmit FIFO between the bus and the modulator.
  vbc_fifo #(.W(vbc_pkg::TXW_W), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wr_done && hit_tx),
    .in_ready_o(fifo_in_ready),
    .in_data_i(writedata_i[vbc_pkg::TXW_W-1:0]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(tx_pull),
    .out_data_o(fifo_word)
  );

  // Two-flop synchroniser for every pin input.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins_i;
      sync2 <= sync1;
    end
  end

  // Bus handshake: accept one cycle after the request, answer for one cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      waitreq <= 1'b1;
      rdata <= 32'h0000_0000;
    end else begin
      waitreq <= !take;
      if (take) begin
        rdata <= rd_mux;
      end
    end
  end

  // Software-written registers take effect on the accepted edge.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl <= vbc_pkg::CTRL_RESET;
      afc <= '0;
    end else if (wr_done) begin
      if (hit_ctrl) begin
        ctrl <= writedata_i[7:0];
      end
      if (hit_afc) begin
        afc <= writedata_i[vbc_pkg::AFC_W-1:0];
      end
    end
  end

  // Rate dividers; both free-run from reset.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      voice_cnt <= '0;
      bit_cnt <= '0;
    end else begin
      voice_cnt <= voice_tick ? 11'h000 : voice_cnt + 11'h001;
      bit_cnt <= bit_tick ? 6'h00 : bit_cnt + 6'h01;
    end
  end

  // Voice capture and playback at 8 kHz. Fresh-sample flag: set wins over the read clear.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      voice_in <= '0;
      voice_pend <= '0;
      voice_dac_o <= '0;
      voice_new <= 1'b0;
    end else begin
      if (wr_done && hit_vout) begin
        voice_pend <= writedata_i[vbc_pkg::VOICE_W-1:0];
      end
      if (voice_tick) begin
        voice_in <= voice_sel;
        voice_dac_o <= voice_pend;
      end
      voice_new <= voice_tick || (voice_new && !(rd_done && hit_vin));
    end
  end

  // Receive I/Q capture on the 270 kHz tick; set wins over the read clear.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_iq <= '0;
      rx_new <= 1'b0;
    end else begin
      if (bit_tick) begin
        rx_iq <= sync2.rx;
      end
      rx_new <= bit_tick || (rx_new && !(rd_done && hit_rx));
    end
  end

  // Modulator: one bit per tick from the FIFO word; stalls while disabled,
  // which lets the FIFO fill and holds further transmit writes in wait.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_shift <= '0;
      tx_left <= '0;
      tx_hist <= '0;
      tx_quad <= '0;
      tx_iq <= '0;
    end else if (tx_load) begin
      tx_shift <= fifo_word;
      tx_left <= 5'(vbc_pkg::TXW_W);
    end else if (tx_step) begin
      tx_shift <= {1'b0, tx_shift[vbc_pkg::TXW_W-1:1]};
      tx_left <= tx_left - 5'h01;
      tx_hist <= {tx_hist[1:0], tx_shift[0]};
      tx_quad <= tx_quad + {!tx_shift[0], 1'b1};
      tx_iq <= gmsk_lut(tx_quad, {tx_hist[1:0], tx_shift[0]});
    end
  end

  // Ramp memory write port.
  always_ff @(posedge clk_i) begin
    if (wr_done && hit_ramp) begin
      ramp_mem[writedata_i[RAMP_IDX_HI:vbc_pkg::RAMP_IDX_LSB]] <= writedata_i[9:0];
    end
  end

  // Ramp playback: restart on each rising burst edge, one step per bit tick, hold at the end.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      burst_q <= 1'b0;
      ramp_idx <= '0;
      ramp_run <= 1'b0;
      ramp_dac_o <= '0;
    end else begin
      burst_q <= sync2.burst;
      if (burst_rise) begin
        ramp_idx <= 4'h0;
        ramp_run <= 1'b1;
      end else if (ramp_run && bit_tick) begin
        ramp_run <= (ramp_idx != 4'(vbc_pkg::RAMP_DEPTH - 2));
        ramp_idx <= ramp_idx + 4'h1;
      end
      ramp_dac_o <= ramp_mem[ramp_idx];
    end
  end

  // ==========================================================
  // Assertions and covers.
  ack_one_cycle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !waitreq |=> waitreq) else $error("waitrequest low for more than one cycle");
  full_stall_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    waitreq && wr_block |=> waitreq) else $error("write accepted into a full FIFO");
  bit_period_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bit_tick |-> ##37 bit_tick) else $error("bit tick period wrong");
  voice_cap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    voice_tick |=> voice_new && voice_in == $past(voice_sel)) else $error("voice capture");
  input_mux_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    voice_tick && ctrl.in_sel |=> voice_in == $past(sync2.aux)) else $error("input mux");
  playback_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    voice_tick |=> voice_dac_o == $past(voice_pend)) else $error("playback sample");
  rx_cap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bit_tick |=> rx_iq == $past(sync2.rx) && rx_new) else $error("rx capture");
  ramp_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    burst_rise |=> ramp_run && ramp_idx == 4'h0 ##1 ramp_dac_o == ramp_mem[0])
    else $error("ramp start");
  ramp_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !ramp_run && !burst_rise |=> $stable(ramp_idx)) else $error("ramp not held");
  afc_load_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_done && hit_afc |=> afc_dac_o == $past(writedata_i[12:0])) else $error("afc load");
  tx_lut_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_step && !tx_load |=> tx_iq_o == gmsk_lut($past(tx_quad),
    {$past(tx_hist[1:0]), $past(tx_shift[0])})) else $error("modulator output");
  tx_bit_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) tx_step);
  burst_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) burst_rise ##1 ramp_run);
  fifo_full_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) wr_block);
  voice_rd_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) rd_done && hit_vin);
endmodule  // vbc_ctl

/* verilog/vbc_pkg.sv */
// Package with register map, field layouts, timing counts and carrier types.
package vbc_pkg;
  // ==========================================================
  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_VOICE_IN = 8'h08;
  localparam logic [7:0] OFS_VOICE_OUT = 8'h0c;
  localparam logic [7:0] OFS_TX_BITS = 8'h10;
  localparam logic [7:0] OFS_RX_IQ = 8'h14;
  localparam logic [7:0] OFS_RAMP = 8'h18;
  localparam logic [7:0] OFS_AFC = 8'h1c;
  localparam logic [7:0] OFS_BAT_V = 8'h20;
  localparam logic [7:0] OFS_BAT_ID = 8'h24;
  localparam logic [7:0] OFS_BAT_T = 8'h28;
  // ==========================================================
  // Field positions and reset values.
  localparam int RAMP_IDX_LSB = 16;
  localparam int RX_Q_LSB = 16;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int VOICE_W = 13;
  localparam int DAC_W = 10;
  localparam int AFC_W = 13;
  localparam int TXW_W = 16;
  localparam int RAMP_DEPTH = 16;
  // ==========================================================
  // Timing: clock and the two sample rates.
  localparam int CLK_HZ = 10000000;
  localparam int VOICE_HZ = 8000;
  localparam int BIT_HZ = 270000;
  localparam int VOICE_DIV = CLK_HZ / VOICE_HZ;
  localparam int BIT_DIV = CLK_HZ / BIT_HZ;
  // ==========================================================
  // Carrier types.
  typedef struct packed {
    logic [3:0] play_gain;  // Playback gain step, shared by earpiece and aux out.
    logic tx_en;            // Lets the transmit modulator consume bits.
    logic aux_out_hi;       // 1 selects +6 dB, 0 selects -15 dB.
    logic aux_in_hi;        // 1 selects +26 dB, 0 selects 0 dB.
    logic in_sel;           // 1 selects the auxiliary input, 0 the microphone.
  } ctrl_t;
  typedef struct packed {
    logic [DAC_W-1:0] i;
    logic [DAC_W-1:0] q;
  } iq_t;
  typedef struct packed {
    logic [VOICE_W-1:0] mic;
    logic [VOICE_W-1:0] aux;
    iq_t rx;
    logic [DAC_W-1:0] bat_v;
    logic [DAC_W-1:0] bat_id;
    logic [DAC_W-1:0] bat_t;
    logic burst;
  } pins_t;
endpackage
